// File: hw/fcs_regs.sv
// Configuration and status register bank with ready and interrupt pins
//
// Contract
// - Config bits 14:12 choose clocks before first burst word.
// - Length code 0 is continuous, 1..4 give 4..32 words, 5..7 reserved.
// - Config bit 8 set bypasses error correction; clear corrects data.
// - Config bit 7 sets ready pin polarity, 1 means high for ready.
// - Config bit 6 sets interrupt pin polarity; default (bit 6 set) passes master bit uninverted.
// - Ready and interrupt pins float until pin enable bit 5 is set.
// - Pin enable clears on cold reset or a written 0; default off.
// - Config bit 4 picks ready one clock early or with valid data.
// - Config bit 0 is read-only write-protect flag, always reads 0.
// - Second configuration location is reserved with no function.
// - Status register is read-only, resets to zero, shows device state.
// - Status bit 15 reads 1 while any internal operation is busy.
// - Status bit 14 set on locked buffer load or locked program/erase.
// - Status bit 13 reads 1 while load busy or failed.
// - Status bit 12 reads 1 while program busy or failed.
// - Status bit 11 reads 1 while erase busy or failed.
// - Status bit 10 flags failure, invalid command or reset abort.
// - Status bit 9 reads 1 while erase is suspended.
// - Status bit 0 timeout flag always reads 0.
// - Master interrupt bit 0 drives pin per interrupt polarity.
// - Burst length and latency apply only in synchronous read mode.
//
// Local design decision: the plain strobed port.
module fcs_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic warm_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic ev_start,
    input wire fcs_pkg::fcs_op_t ev_kind,
    input wire logic ev_pass,
    input wire logic ev_fail,
    input wire logic ev_locked,
    input wire logic ev_invalid,
    input wire logic ev_suspend,
    input wire logic ev_resume,
    input wire logic ev_abort,
    input wire logic otp_locked,
    input wire logic irq_master,
    input wire logic word_valid,
    input wire logic word_valid_next,
    output logic sync_read_sel,
    output logic [3:0] burst_latency_clks,
    output logic [5:0] burst_len_words,
    output logic ecc_bypass,
    output logic rdy_out,
    output logic rdy_oe_n,
    output logic irq_out,
    output logic irq_oe_n
);
    logic [15:0] cfg_q;
    logic [15:0] stat_q;
    logic [15:0] rdata_q;
    logic [2:0] len_code;
    logic rdy_active;
    logic ev_above_resume;

    // Latency clocks for a latency code; low codes wrap to the long settings
    function automatic logic [3:0] lat_clks(input logic [2:0] code);
        if (code <= fcs_pkg::LAT_WRAP_CODE) begin
            lat_clks = {1'b0, code} + fcs_pkg::LAT_WRAP_ADD;
        end else begin
            lat_clks = {1'b0, code};
        end
    endfunction : lat_clks

    // Words per burst for a length code, zero meaning continuous
    function automatic logic [5:0] len_words(input logic [2:0] code);
        if (code == fcs_pkg::LEN_CONT) begin
            len_words = 6'h00;
        end else begin
            len_words = fcs_pkg::LEN_BASE_WORDS << (code - 3'h1);
        end
    endfunction : len_words

    // Configuration register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= fcs_pkg::CFG_RESET;
        end else if (warm_rst) begin
            cfg_q <= (fcs_pkg::CFG_RESET
                & ~(16'h0001 << fcs_pkg::CFG_PINOE))
                | (cfg_q & (16'h0001 << fcs_pkg::CFG_PINOE));
        end else if (reg_wr && reg_addr == fcs_pkg::ADDR_CFG) begin
            cfg_q <= (reg_wdata & fcs_pkg::CFG_WMASK)
                | (cfg_q & ~fcs_pkg::CFG_WMASK);
            if (reg_wdata[fcs_pkg::CFG_LEN_HI:fcs_pkg::CFG_LEN_LO]
                    > fcs_pkg::LEN_MAX_CODE) begin
                cfg_q[fcs_pkg::CFG_LEN_HI:fcs_pkg::CFG_LEN_LO] <=
                    cfg_q[fcs_pkg::CFG_LEN_HI:fcs_pkg::CFG_LEN_LO];
            end
        end
    end

    assign len_code = cfg_q[fcs_pkg::CFG_LEN_HI:fcs_pkg::CFG_LEN_LO];
    assign sync_read_sel = cfg_q[fcs_pkg::CFG_SYNC];
    assign ecc_bypass = cfg_q[fcs_pkg::CFG_ECC];
    assign burst_latency_clks = sync_read_sel
        ? lat_clks(cfg_q[fcs_pkg::CFG_LAT_HI:fcs_pkg::CFG_LAT_LO]) : 4'h0;
    assign burst_len_words = sync_read_sel ? len_words(len_code) : 6'h00;

    // Any event that outranks a resume in the same cycle
    assign ev_above_resume = ev_abort || ev_locked || ev_start || ev_fail
        || ev_pass || ev_invalid || ev_suspend;

    // Status register driven by controller events; in one cycle abort wins, then locked, start, fail, pass, invalid, suspend, resume
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= fcs_pkg::STAT_RESET;
        end else if (warm_rst) begin
            stat_q <= fcs_pkg::STAT_RESET;
        end else if (ev_abort) begin
            stat_q[fcs_pkg::ST_ONGO] <= 1'b0;
            stat_q[fcs_pkg::ST_ERR] <= 1'b1;
            stat_q[fcs_pkg::ST_RSTB] <= 1'b1;
        end else if (ev_locked) begin
            stat_q[fcs_pkg::ST_ONGO] <= 1'b0;
            stat_q[fcs_pkg::ST_LOCK] <= 1'b1;
            stat_q[fcs_pkg::ST_ERR] <= 1'b1;
            stat_q[fcs_pkg::ST_LOAD] <= ev_kind == fcs_pkg::OP_LOAD;
            stat_q[fcs_pkg::ST_PROG] <= ev_kind == fcs_pkg::OP_PROG;
            stat_q[fcs_pkg::ST_ERASE] <= ev_kind == fcs_pkg::OP_ERASE;
        end else if (ev_start) begin
            stat_q[fcs_pkg::ST_ONGO] <= 1'b1;
            stat_q[fcs_pkg::ST_LOCK] <= 1'b0;
            stat_q[fcs_pkg::ST_ERR] <= 1'b0;
            stat_q[fcs_pkg::ST_RSTB] <= 1'b0;
            stat_q[fcs_pkg::ST_LOAD] <= ev_kind == fcs_pkg::OP_LOAD;
            stat_q[fcs_pkg::ST_PROG] <= ev_kind == fcs_pkg::OP_PROG;
            stat_q[fcs_pkg::ST_ERASE] <= ev_kind == fcs_pkg::OP_ERASE
                || stat_q[fcs_pkg::ST_SUS];
        end else if (ev_fail) begin
            // failed operation keeps its kind bit
            stat_q[fcs_pkg::ST_ONGO] <= 1'b0;
            stat_q[fcs_pkg::ST_ERR] <= 1'b1;
        end else if (ev_pass) begin
            stat_q[fcs_pkg::ST_ONGO] <= 1'b0;
            stat_q[fcs_pkg::ST_LOAD] <= 1'b0;
            stat_q[fcs_pkg::ST_PROG] <= 1'b0;
            stat_q[fcs_pkg::ST_ERASE] <= stat_q[fcs_pkg::ST_SUS];
        end else if (ev_invalid) begin
            stat_q[fcs_pkg::ST_ONGO] <= 1'b0;
            stat_q[fcs_pkg::ST_ERR] <= 1'b1;
            stat_q[fcs_pkg::ST_LOCK] <= 1'b0;
            stat_q[fcs_pkg::ST_LOAD] <= 1'b0;
            stat_q[fcs_pkg::ST_PROG] <= 1'b0;
            stat_q[fcs_pkg::ST_ERASE] <= stat_q[fcs_pkg::ST_SUS];
        end else if (ev_suspend) begin
            stat_q[fcs_pkg::ST_ONGO] <= 1'b0;
            stat_q[fcs_pkg::ST_SUS] <= 1'b1;
            stat_q[fcs_pkg::ST_ERASE] <= 1'b1;
            stat_q[fcs_pkg::ST_ERR] <= 1'b0;
        end else if (ev_resume) begin
            stat_q[fcs_pkg::ST_SUS] <= 1'b0;
            stat_q[fcs_pkg::ST_ONGO] <= 1'b1;
            stat_q[fcs_pkg::ST_ERASE] <= 1'b1;
            stat_q[fcs_pkg::ST_LOAD] <= 1'b0;
            stat_q[fcs_pkg::ST_PROG] <= 1'b0;
            stat_q[fcs_pkg::ST_ERR] <= 1'b0;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (!reg_rd) begin
            rdata_q <= 16'h0000;
        end else if (reg_addr == fcs_pkg::ADDR_CFG) begin
            rdata_q <= cfg_q;
            rdata_q[fcs_pkg::CFG_WPROT] <= fcs_pkg::CFG_WPROT_VAL;
        end else if (reg_addr == fcs_pkg::ADDR_STAT) begin
            rdata_q <= stat_q;
            rdata_q[fcs_pkg::ST_OTPL] <= otp_locked;
            rdata_q[fcs_pkg::ST_TOUT] <= fcs_pkg::ST_TOUT_VAL;
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign reg_rdata = rdata_q;

    assign rdy_active = cfg_q[fcs_pkg::CFG_RDYCONF] ? word_valid
        : word_valid_next;
    assign rdy_out = cfg_q[fcs_pkg::CFG_READY_POLARITY] ? rdy_active : ~rdy_active;
    assign irq_out = cfg_q[fcs_pkg::CFG_IRQPOL] ? irq_master : ~irq_master;
    assign rdy_oe_n = ~cfg_q[fcs_pkg::CFG_PINOE];
    assign irq_oe_n = ~cfg_q[fcs_pkg::CFG_PINOE];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_pins_float_off: assert property (
        !cfg_q[fcs_pkg::CFG_PINOE] |-> (rdy_oe_n && irq_oe_n))
        else $error("pins driven while disabled");

    a_pin_enable_write: assert property (
        reg_wr && !warm_rst && reg_addr == fcs_pkg::ADDR_CFG
        |=> irq_oe_n == !$past(reg_wdata[fcs_pkg::CFG_PINOE]))
        else $error("pin enable not taken from write");

    a_irq_pol_map: assert property (
        !irq_master && !irq_oe_n
        |-> irq_out == !cfg_q[fcs_pkg::CFG_IRQPOL])
        else $error("interrupt pin level wrong");

    a_rdy_early: assert property (
        !cfg_q[fcs_pkg::CFG_RDYCONF] && cfg_q[fcs_pkg::CFG_READY_POLARITY]
        |-> rdy_out == word_valid_next)
        else $error("ready not one clock early");

    a_async_no_burst: assert property (
        !sync_read_sel |-> burst_len_words == 6'h00
        && burst_latency_clks == 4'h0)
        else $error("burst settings active in async mode");

    a_wprot_reads_zero: assert property (
        reg_rd && reg_addr == fcs_pkg::ADDR_CFG |=> reg_rdata[0] == 1'b0)
        else $error("write-protect flag not zero");

    a_rdata_one_cycle: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");

    a_start_busy: assert property (
        ev_start && !ev_abort && !ev_locked && !warm_rst
        |=> stat_q[fcs_pkg::ST_ONGO] ##1 stat_q[fcs_pkg::ST_ONGO]
        || $past(ev_pass || ev_fail || ev_abort || ev_locked
        || ev_invalid || ev_suspend || warm_rst))
        else $error("busy flag not set on start");

    a_lock_sets: assert property (
        ev_locked && !ev_abort && !warm_rst
        |=> stat_q[fcs_pkg::ST_LOCK] && stat_q[fcs_pkg::ST_ERR])
        else $error("lock flag not set");

    a_fail_error: assert property (
        ev_fail && !ev_start && !ev_locked && !ev_abort && !warm_rst
        |=> stat_q[fcs_pkg::ST_ERR] && !stat_q[fcs_pkg::ST_ONGO])
        else $error("error flag not set on failure");

    a_suspend_flag: assert property (
        ev_suspend && !(ev_abort || ev_locked || ev_start || ev_fail
        || ev_pass || ev_invalid || warm_rst)
        |=> stat_q[fcs_pkg::ST_SUS] && stat_q[fcs_pkg::ST_ERASE])
        else $error("suspend flag not set");

    a_resume_clears: assert property (
        ev_resume && !ev_above_resume && !warm_rst
        |=> !stat_q[fcs_pkg::ST_SUS] && stat_q[fcs_pkg::ST_ONGO])
        else $error("suspend flag not cleared on resume");

    a_abort_flags: assert property (
        ev_abort && !warm_rst
        |=> stat_q[fcs_pkg::ST_ERR] && stat_q[fcs_pkg::ST_RSTB]
        && !stat_q[fcs_pkg::ST_ONGO])
        else $error("abort not reported");

    a_load_kind: assert property (
        ev_start && ev_kind == fcs_pkg::OP_LOAD && !ev_abort && !ev_locked
        && !warm_rst
        |=> stat_q[fcs_pkg::ST_LOAD] && !stat_q[fcs_pkg::ST_PROG])
        else $error("load bit not set on load start");

    a_prog_kind: assert property (
        ev_start && ev_kind == fcs_pkg::OP_PROG && !ev_abort && !ev_locked
        && !warm_rst
        |=> stat_q[fcs_pkg::ST_PROG] && !stat_q[fcs_pkg::ST_LOAD])
        else $error("program bit not set on program start");

    a_erase_kind: assert property (
        ev_start && ev_kind == fcs_pkg::OP_ERASE && !ev_abort && !ev_locked
        && !warm_rst |=> stat_q[fcs_pkg::ST_ERASE])
        else $error("erase bit not set on erase start");

    a_stat_read_only: assert property (
        reg_wr && reg_addr == fcs_pkg::ADDR_STAT && !ev_above_resume
        && !ev_resume && !warm_rst |=> $stable(stat_q))
        else $error("status changed by a host write");

    a_len_reserved: assert property (
        reg_wr && !warm_rst && reg_addr == fcs_pkg::ADDR_CFG
        && reg_wdata[fcs_pkg::CFG_LEN_HI:fcs_pkg::CFG_LEN_LO]
        > fcs_pkg::LEN_MAX_CODE
        |=> $stable(cfg_q[fcs_pkg::CFG_LEN_HI:fcs_pkg::CFG_LEN_LO]))
        else $error("reserved burst length code taken");

    a_ecc_write: assert property (
        reg_wr && !warm_rst && reg_addr == fcs_pkg::ADDR_CFG
        |=> ecc_bypass == $past(reg_wdata[fcs_pkg::CFG_ECC]))
        else $error("correction bypass not taken from write");

    a_rdy_aligned: assert property (
        cfg_q[fcs_pkg::CFG_RDYCONF] && cfg_q[fcs_pkg::CFG_READY_POLARITY]
        |-> rdy_out == word_valid)
        else $error("ready not aligned with data");

    a_rdy_low_pol: assert property (
        !cfg_q[fcs_pkg::CFG_READY_POLARITY] && !cfg_q[fcs_pkg::CFG_RDYCONF]
        |-> rdy_out == !word_valid_next)
        else $error("ready polarity not inverted");

    a_timeout_zero: assert property (
        reg_rd && reg_addr == fcs_pkg::ADDR_STAT
        |=> reg_rdata[fcs_pkg::ST_TOUT] == 1'b0)
        else $error("timeout flag not zero");

    a_spare_zero: assert property (
        reg_rd && reg_addr == fcs_pkg::ADDR_SPARE
        |=> reg_rdata == 16'h0000)
        else $error("reserved location read not zero");

    a_warm_keeps_oe: assert property (
        warm_rst |=> $stable(cfg_q[fcs_pkg::CFG_PINOE])
        && stat_q == fcs_pkg::STAT_RESET)
        else $error("warm reset lost pin enable");

    c_load_pass: cover property (
        ev_start && ev_kind == fcs_pkg::OP_LOAD ##[1:20] ev_pass);
    c_suspend_resume: cover property (ev_suspend ##[1:20] ev_resume);
    c_pins_enabled: cover property ($fell(irq_oe_n));
    c_sync_burst: cover property (sync_read_sel && burst_len_words != 6'h00);
    c_abort_after_start: cover property (ev_start ##[1:20] ev_abort);
endmodule : fcs_regs

// File: hw/fcs_pkg.sv
// Shared constants for the flash configuration and status register bank
package fcs_pkg;
    // Register offsets on the host register port
    localparam logic [15:0] ADDR_CFG = 16'hF221;
    localparam logic [15:0] ADDR_SPARE = 16'hF222;
    localparam logic [15:0] ADDR_STAT = 16'hF240;

    // Configuration register reset value and field positions
    localparam logic [15:0] CFG_RESET = 16'h40C0;
    localparam int CFG_SYNC = 15;
    localparam int CFG_LAT_HI = 14;
    localparam int CFG_LAT_LO = 12;
    localparam int CFG_LEN_HI = 11;
    localparam int CFG_LEN_LO = 9;
    localparam int CFG_ECC = 8;
    localparam int CFG_READY_POLARITY = 7;
    localparam int CFG_IRQPOL = 6;
    localparam int CFG_PINOE = 5;
    localparam int CFG_RDYCONF = 4;
    localparam int CFG_WPROT = 0;
    // Bits that software may write; the others are fixed
    localparam logic [15:0] CFG_WMASK = 16'hFFF0;
    localparam logic CFG_WPROT_VAL = 1'b0;

    // Status register reset value and field positions
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam int ST_ONGO = 15;
    localparam int ST_LOCK = 14;
    localparam int ST_LOAD = 13;
    localparam int ST_PROG = 12;
    localparam int ST_ERASE = 11;
    localparam int ST_ERR = 10;
    localparam int ST_SUS = 9;
    localparam int ST_RSTB = 7;
    localparam int ST_OTPL = 6;
    localparam int ST_TOUT = 0;
    localparam logic ST_TOUT_VAL = 1'b0;

    // Burst field codes and decoded values
    localparam logic [2:0] LEN_CONT = 3'h0;
    localparam logic [2:0] LEN_MAX_CODE = 3'h4;
    localparam logic [5:0] LEN_BASE_WORDS = 6'h04;
    localparam logic [2:0] LAT_WRAP_CODE = 3'h2;
    localparam logic [3:0] LAT_WRAP_ADD = 4'h8;

    // Kind of internal operation reported by the controller
    typedef enum logic [1:0] {
        OP_LOAD = 2'b00,
        OP_PROG = 2'b01,
        OP_ERASE = 2'b10,
        OP_VERIFY = 2'b11
    } fcs_op_t;
endpackage : fcs_pkg

// File: sim/fcs_host.sv
// Host bus master model driving the register port
module fcs_host (
    input wire logic clk,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write strobe beside address and data
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : fcs_host

// File: sim/test_fcs_regs.sv
// Self-checking testbench for the configuration and status register bank
module test_fcs_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic warm_rst = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, d, cfg;
    logic reg_wr, reg_rd, sync_sel, ecc, rdy, rdy_oe_n, irq, irq_oe_n;
    logic [7:0] ev = 8'h00;
    fcs_pkg::fcs_op_t kind = fcs_pkg::OP_LOAD;
    logic otp = 1'b0, irqm = 1'b0, wv = 1'b0, wvn = 1'b0;
    logic [3:0] lat_clks;
    logic [5:0] len_words;
    logic [2:0] lat;
    integer seed = 32'h7E4A;
    int err_count = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    fcs_host i_fcs_host (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    fcs_regs i_fcs_regs (.clk(clk), .rst(rst), .warm_rst(warm_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_start(ev[5]),
        .ev_kind(kind), .ev_pass(ev[3]), .ev_fail(ev[4]),
        .ev_locked(ev[6]), .ev_invalid(ev[2]), .ev_suspend(ev[1]),
        .ev_resume(ev[0]), .ev_abort(ev[7]), .otp_locked(otp),
        .irq_master(irqm), .word_valid(wv), .word_valid_next(wvn),
        .sync_read_sel(sync_sel), .burst_latency_clks(lat_clks),
        .burst_len_words(len_words), .ecc_bypass(ecc), .rdy_out(rdy),
        .rdy_oe_n(rdy_oe_n), .irq_out(irq), .irq_oe_n(irq_oe_n));
    function automatic logic [5:0] exp_len(input logic [2:0] c);
        case (c)
            3'h1: return 6'h04;
            3'h2: return 6'h08;
            3'h3: return 6'h10;
            3'h4: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction : exp_len
    function automatic logic exp_rdy(input logic [15:0] c, input logic v,
                                     input logic vn);
        logic act;
        act = c[4] ? v : vn;
        return c[7] ? act : ~act;
    endfunction : exp_rdy
    function automatic logic [3:0] exp_lat(input logic [2:0] l);
        return (l < 3'h3) ? {1'b0, l} + 4'h8 : {1'b0, l};
    endfunction : exp_lat
    task automatic test_done();
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task automatic chk1(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %b seen %b", n, e, g);
            err_count++;
        end
    endtask : chk1
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        i_fcs_host.rd(a, d);
        chk("register", e, d);
    endtask : rd_chk
    // Pulse one event for a cycle, then read the status back
    task automatic step(input int i, input fcs_pkg::fcs_op_t k,
                        input logic [15:0] e);
        @(posedge clk);
        ev <= 8'h01 << i;
        kind <= k;
        @(posedge clk);
        ev <= 8'h00;
        rd_chk(fcs_pkg::ADDR_STAT, e);
    endtask : step
    initial begin
        #100000;
        err_count++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk1("rdy_oe_n", 1'b1, rdy_oe_n);
        rd_chk(fcs_pkg::ADDR_CFG, 16'h40C0);
        rd_chk(fcs_pkg::ADDR_STAT, 16'h0000);
        for (int c = 0; c < 5; c++) begin
            lat = 3'($random(seed));
            cfg = {1'b1, lat, 3'(c), 9'h0C0};
            i_fcs_host.wr(fcs_pkg::ADDR_CFG, cfg);
            #1;
            chk("len", {10'h0, exp_len(3'(c))}, {10'h0, len_words});
            chk("lat", {12'h0, exp_lat(lat)}, {12'h0, lat_clks});
            chk1("sync_read_sel", 1'b1, sync_sel);
            rd_chk(fcs_pkg::ADDR_CFG, cfg);
        end
        i_fcs_host.wr(fcs_pkg::ADDR_CFG, 16'hFFFF);
        rd_chk(fcs_pkg::ADDR_CFG, 16'hF9F0);
        chk1("ecc_bypass", 1'b1, ecc);
        i_fcs_host.wr(fcs_pkg::ADDR_CFG, 16'h0000);
        #1;
        chk("async", 16'h0000, {6'h0, len_words, lat_clks});
        chk1("sync_read_sel", 1'b0, sync_sel);
        chk1("ecc_bypass", 1'b0, ecc);
        chk1("irq_oe_n", 1'b1, irq_oe_n);
        for (int i = 0; i < 8; i++) begin
            cfg = 16'($random(seed)) | 16'h0020;
            i_fcs_host.wr(fcs_pkg::ADDR_CFG, cfg);
            @(posedge clk);
            irqm <= 1'($random(seed));
            wv <= 1'($random(seed));
            wvn <= 1'($random(seed));
            #1;
            chk1("irq_oe_n", 1'b0, irq_oe_n);
            chk1("rdy_oe_n", 1'b0, rdy_oe_n);
            chk1("ecc_bypass", cfg[8], ecc);
            chk1("irq_out", cfg[6] ? irqm : ~irqm, irq);
            chk1("rdy_out", exp_rdy(cfg, wv, wvn), rdy);
        end
        @(posedge clk);
        warm_rst <= 1'b1;
        @(posedge clk);
        warm_rst <= 1'b0;
        rd_chk(fcs_pkg::ADDR_CFG, 16'h40E0);
        i_fcs_host.wr(fcs_pkg::ADDR_STAT, 16'hFFFF);
        i_fcs_host.wr(fcs_pkg::ADDR_SPARE, 16'hFFFF);
        rd_chk(fcs_pkg::ADDR_SPARE, 16'h0000);
        @(posedge clk);
        otp <= 1'b1;
        rd_chk(fcs_pkg::ADDR_STAT, 16'h0040);
        @(posedge clk);
        otp <= 1'b0;
        step(5, fcs_pkg::OP_LOAD, 16'hA000);
        step(4, fcs_pkg::OP_LOAD, 16'h2400);
        step(5, fcs_pkg::OP_PROG, 16'h9000);
        step(3, fcs_pkg::OP_PROG, 16'h0000);
        step(2, fcs_pkg::OP_LOAD, 16'h0400);
        step(5, fcs_pkg::OP_VERIFY, 16'h8000);
        step(3, fcs_pkg::OP_VERIFY, 16'h0000);
        step(5, fcs_pkg::OP_ERASE, 16'h8800);
        step(1, fcs_pkg::OP_ERASE, 16'h0A00);
        step(5, fcs_pkg::OP_LOAD, 16'hAA00);
        step(3, fcs_pkg::OP_LOAD, 16'h0A00);
        step(0, fcs_pkg::OP_ERASE, 16'h8800);
        step(3, fcs_pkg::OP_ERASE, 16'h0000);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(fcs_pkg::ADDR_STAT, 16'h0000);
        chk1("rdy_oe_n", 1'b1, rdy_oe_n);
        step(6, fcs_pkg::OP_PROG, 16'h5400);
        step(5, fcs_pkg::OP_LOAD, 16'hA000);
        step(7, fcs_pkg::OP_LOAD, 16'h2480);
        test_done();
    end
endmodule : test_fcs_regs
